// [rtl/wut_pkg.sv]
// Package of offsets, field layouts and reset values for the wake-up timer interrupt block.
package wut_pkg;

    // Byte addresses of the documented registers.
    localparam logic [31:0] WUT_FIELD_D_LOW_ADDR = 32'h4000_2520;
    localparam logic [31:0] WUT_FIELD_D_HIGH_ADDR = 32'h4000_2524;
    localparam logic [31:0] WUT_INT_ENABLE_ADDR = 32'h4000_2528;
    localparam logic [31:0] WUT_STATUS_ADDR = 32'h4000_252c;
    localparam logic [31:0] WUT_INT_CLEAR_ADDR = 32'h4000_2530;
    localparam logic [31:0] WUT_FIELD_A_LOW_ADDR = 32'h4000_253c;
    localparam logic [31:0] WUT_FIELD_A_HIGH_ADDR = 32'h4000_2540;

    // Control and count registers placed in free space of the map.
    localparam logic [31:0] WUT_CONTROL_ADDR = 32'h4000_2544;
    localparam logic [31:0] WUT_COUNT_LOW_ADDR = 32'h4000_2548;
    localparam logic [31:0] WUT_COUNT_HIGH_ADDR = 32'h4000_254c;

    // Reset values of the compare halves.
    localparam logic [15:0] WUT_FIELD_D_LOW_RST = 16'h3fff;
    localparam logic [15:0] WUT_FIELD_D_HIGH_RST = 16'h0000;
    localparam logic [15:0] WUT_FIELD_A_LOW_RST = 16'h1900;
    localparam logic [15:0] WUT_FIELD_A_HIGH_RST = 16'h0000;

    // Interrupt source bit positions shared by enable, status and clear.
    localparam int WUT_BIT_MATCH_A = 0;
    localparam int WUT_BIT_MATCH_B = 1;
    localparam int WUT_BIT_MATCH_C = 2;
    localparam int WUT_BIT_MATCH_D = 3;
    localparam int WUT_BIT_ROLL = 4;
    localparam int WUT_NUM_SRC = 5;

    // Status-only bit positions.
    localparam int WUT_BIT_IRQ_PENDING = 6;
    localparam int WUT_BIT_FROZEN = 7;
    localparam int WUT_BIT_EN_PENDING = 8;

    // Control register layout and reset value.
    localparam int WUT_CTL_ENABLE = 0;
    localparam int WUT_CTL_FREE_RUN = 1;
    localparam int WUT_CTL_FREEZE = 2;
    localparam logic [2:0] WUT_CTL_RST = 3'h2;

    // Count value at which a free-running counter wraps.
    localparam logic [31:0] WUT_COUNT_MAX = 32'hffff_ffff;

endpackage : wut_pkg

// [rtl/wut_counter.sv]
// Wake-up count and compare engine advanced by the slow-domain tick.
`timescale 1ns/1ps
module wut_counter
    import wut_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic slow_tick, // One-cycle pulse per slow-domain edge.
    input wire logic enable, // Counter enable as seen in the slow domain.
    input wire logic free_run, // High for free running, low for periodic.
    input wire logic [31:0] field_a, // Compare field A.
    input wire logic [31:0] field_d, // Compare field D, periodic limit.
    output logic [31:0] count_q, // Current count value.
    output logic hit_a_q, // Pulse when the count reaches field A.
    output logic hit_d_q, // Pulse when the count reaches field D.
    output logic roll_q // Pulse when a free-running count wraps.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Counting.

    logic step; // The count moves on this cycle.

    assign step = slow_tick && enable;

    // Periodic mode restarts after reaching field D; free running wraps naturally.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_q <= 32'h0000_0000;
        end else if (step) begin
            if (!free_run && (count_q == field_d)) begin
                count_q <= 32'h0000_0000;
            end else begin
                count_q <= count_q + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and rollover events.

    // Each event is a registered one-cycle pulse so the flag logic sees clean edges.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hit_a_q <= 1'b0;
            hit_d_q <= 1'b0;
            roll_q <= 1'b0;
        end else begin
            hit_a_q <= step && (count_q == field_a);
            hit_d_q <= step && (count_q == field_d);
            roll_q <= step && free_run && (count_q == WUT_COUNT_MAX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_periodic_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        (step && !free_run && count_q == field_d) |=> (count_q == 32'h0000_0000 && hit_d_q))
        else $error("Periodic count did not restart at field D.");

    chk_roll_free_running_mode: assert property (@(posedge sys_clk) disable iff (rst)
        roll_q |-> ($past(free_run) && $past(count_q) == WUT_COUNT_MAX && count_q == 32'h0))
        else $error("Rollover pulse outside a free-running wrap.");

endmodule : wut_counter

// [rtl/wut_irq_top.sv]
// Wake-up timer compare, status, clear and interrupt logic with its register port.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module wut_irq_top
    import wut_pkg::*;
(
    input wire logic sys_clk, // System clock, 25 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic slow_tick, // One-cycle pulse per 32 kHz domain edge.
    input wire logic match_b, // Field B comparison hit pulse.
    input wire logic match_c, // Field C comparison hit pulse.
    input wire logic [31:0] addr, // Register byte address.
    input wire logic [31:0] wr_data, // Register write data.
    input wire logic wr_en, // Write strobe, one cycle.
    input wire logic rd_en, // Read strobe, one cycle.
    output logic [31:0] rd_data_q, // Read data, valid the cycle after rd_en.
    output logic irq_q // Level interrupt output.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [15:0] fd_low_q; // Field D low half.
    logic [15:0] fd_high_q; // Field D high half.
    logic [15:0] fa_low_q; // Field A low half.
    logic [15:0] fa_high_q; // Field A high half.
    logic [WUT_NUM_SRC-1:0] ien_q; // Interrupt enables.
    logic [WUT_NUM_SRC-1:0] flag_q; // Sticky flags held in the slow domain.
    logic [WUT_NUM_SRC-1:0] clr_q; // Clear requests waiting for a slow edge.
    logic [2:0] ctl_q; // Control: enable, free running, freeze.
    logic en_slow_q; // Enable as taken by the slow domain.
    logic en_pend_q; // Enable change not yet synchronised.
    logic [15:0] hold_q; // Frozen copy of the high count half.
    logic frozen_q; // High half is held.
    logic [31:0] count; // Live count.
    logic hit_a; // Field A hit pulse.
    logic hit_d; // Field D hit pulse.
    logic roll; // Rollover pulse.
    logic [WUT_NUM_SRC-1:0] hits; // All event pulses by bit position.
    logic [WUT_NUM_SRC-1:0] clr_wr; // Clear bits written this cycle.
    logic [15:0] status; // Assembled status word.

    // True when a strobe addresses the given register.
    function automatic logic sel(input logic [31:0] a, input logic [31:0] reg_addr);
        sel = (a == reg_addr);
    endfunction : sel

    // Zero-extends a 16-bit register into the read word.
    function automatic logic [31:0] ext16(input logic [15:0] v);
        ext16 = {16'h0000, v};
    endfunction : ext16

    ////////////////////////////////////////////////////////////////////////////////
    // Count engine.

    wut_counter i_wut_counter (
        .sys_clk(sys_clk),
        .rst(rst),
        .slow_tick(slow_tick),
        .enable(en_slow_q),
        .free_run(ctl_q[WUT_CTL_FREE_RUN]),
        .field_a({fa_high_q, fa_low_q}),
        .field_d({fd_high_q, fd_low_q}),
        .count_q(count),
        .hit_a_q(hit_a),
        .hit_d_q(hit_d),
        .roll_q(roll)
    );

    assign hits = {roll, hit_d, match_c, match_b, hit_a};
    assign clr_wr = (wr_en && sel(addr, WUT_INT_CLEAR_ADDR)) ? wr_data[WUT_NUM_SRC-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare fields.

    // Both fields are written as independent 16-bit halves.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fd_low_q <= WUT_FIELD_D_LOW_RST;
            fd_high_q <= WUT_FIELD_D_HIGH_RST;
            fa_low_q <= WUT_FIELD_A_LOW_RST;
            fa_high_q <= WUT_FIELD_A_HIGH_RST;
        end else if (wr_en) begin
            if (sel(addr, WUT_FIELD_D_LOW_ADDR)) begin
                fd_low_q <= wr_data[15:0];
            end
            if (sel(addr, WUT_FIELD_D_HIGH_ADDR)) begin
                fd_high_q <= wr_data[15:0];
            end
            if (sel(addr, WUT_FIELD_A_LOW_ADDR)) begin
                fa_low_q <= wr_data[15:0];
            end
            if (sel(addr, WUT_FIELD_A_HIGH_ADDR)) begin
                fa_high_q <= wr_data[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt enables.

    // Bits 0 to 3 gate the compare flags, bit 4 the rollover flag.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ien_q <= '0;
        end else if (wr_en && sel(addr, WUT_INT_ENABLE_ADDR)) begin
            ien_q <= wr_data[WUT_NUM_SRC-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clear requests.

    // A request waits for the next slow edge, then drops by itself.
    // A bit written in the very cycle of that edge survives to the next one.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clr_q <= '0;
        end else if (slow_tick) begin
            clr_q <= clr_wr;
        end else begin
            clr_q <= clr_q | clr_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky flags.

    // Flags only drop on a slow edge carrying a clear; a hit in that cycle wins.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flag_q <= '0;
        end else if (slow_tick) begin
            flag_q <= (flag_q & ~clr_q) | hits;
        end else begin
            flag_q <= flag_q | hits;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control and enable synchronisation.

    // The enable reaches the counter only at a slow edge, so software sees a
    // pending bit until then; the limitation is one slow period of latency.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= WUT_CTL_RST;
        end else if (wr_en && sel(addr, WUT_CONTROL_ADDR)) begin
            ctl_q <= wr_data[2:0];
        end
    end

    // Slow copy of the enable and its pending flag; a new change wins over the edge.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            en_slow_q <= 1'b0;
            en_pend_q <= 1'b0;
        end else begin
            if (slow_tick) begin
                en_slow_q <= ctl_q[WUT_CTL_ENABLE];
            end
            if (wr_en && sel(addr, WUT_CONTROL_ADDR)
                && (wr_data[WUT_CTL_ENABLE] != ctl_q[WUT_CTL_ENABLE])) begin
                en_pend_q <= 1'b1;
            end else if (slow_tick) begin
                en_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Freeze of the high count half.

    // Reading the low half with freeze on captures the high half for an atomic pair.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hold_q <= 16'h0000;
            frozen_q <= 1'b0;
        end else if (rd_en && sel(addr, WUT_COUNT_LOW_ADDR) && ctl_q[WUT_CTL_FREEZE]) begin
            hold_q <= count[31:16];
            frozen_q <= 1'b1;
        end else if (rd_en && sel(addr, WUT_COUNT_HIGH_ADDR)) begin
            frozen_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Status assembly; bit 6 tells software whether power-down is safe yet.
    always_comb begin
        status = 16'h0000;
        status[WUT_NUM_SRC-1:0] = flag_q;
        status[WUT_BIT_IRQ_PENDING] = |flag_q;
        status[WUT_BIT_FROZEN] = frozen_q;
        status[WUT_BIT_EN_PENDING] = en_pend_q;
    end

    // Data stand only in the cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= 32'h0000_0000;
        end else if (!rd_en) begin
            rd_data_q <= 32'h0000_0000;
        end else begin
            case (addr)
                WUT_FIELD_D_LOW_ADDR: rd_data_q <= ext16(fd_low_q);
                WUT_FIELD_D_HIGH_ADDR: rd_data_q <= ext16(fd_high_q);
                WUT_FIELD_A_LOW_ADDR: rd_data_q <= ext16(fa_low_q);
                WUT_FIELD_A_HIGH_ADDR: rd_data_q <= ext16(fa_high_q);
                WUT_INT_ENABLE_ADDR: rd_data_q <= {27'h0, ien_q};
                WUT_STATUS_ADDR: rd_data_q <= ext16(status);
                WUT_INT_CLEAR_ADDR: rd_data_q <= {27'h0, clr_q};
                WUT_CONTROL_ADDR: rd_data_q <= {29'h0, ctl_q};
                WUT_COUNT_LOW_ADDR: rd_data_q <= ext16(count[15:0]);
                WUT_COUNT_HIGH_ADDR: rd_data_q <= ext16(frozen_q ? hold_q : count[31:16]);
                default: rd_data_q <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt output.

    // Registered so the pin is glitch free.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flag_q & ien_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_flag_set_hit: assert property (@(posedge sys_clk) disable iff (rst)
        (hits != '0) |=> ((flag_q & $past(hits)) == $past(hits)))
        else $error("Event did not set its flag.");

    chk_flag_clear_edge: assert property (@(posedge sys_clk) disable iff (rst)
        (slow_tick && clr_q[WUT_BIT_MATCH_A] && !hits[WUT_BIT_MATCH_A])
        |=> !flag_q[WUT_BIT_MATCH_A])
        else $error("Cleared flag stayed set.");

    chk_clear_selfclr: assert property (@(posedge sys_clk) disable iff (rst)
        (slow_tick && clr_wr == '0) |=> (clr_q == '0))
        else $error("Clear request did not self-clear.");

    chk_irq_output: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 (irq_q == |($past(flag_q) & $past(ien_q))))
        else $error("Interrupt output mismatches enabled flags.");

    chk_pending_status: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_en && addr == WUT_STATUS_ADDR)
        |=> (rd_data_q[WUT_BIT_IRQ_PENDING] == ($past(flag_q) != '0)))
        else $error("Pending bit disagrees with flags.");

    chk_enable_pending: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && addr == WUT_CONTROL_ADDR && wr_data[0] != ctl_q[0])
        |=> en_pend_q)
        else $error("Enable change did not raise pending.");

    // A slow edge with no competing control write must retire the pending change.
    chk_enable_release: assert property (@(posedge sys_clk) disable iff (rst)
        (slow_tick && !(wr_en && addr == WUT_CONTROL_ADDR))
        |=> (!en_pend_q && en_slow_q == $past(ctl_q[WUT_CTL_ENABLE])))
        else $error("Enable change not taken at the slow edge.");

    chk_status_frozen: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_en && addr == WUT_STATUS_ADDR)
        |=> (rd_data_q[WUT_BIT_FROZEN] == $past(frozen_q)
            && rd_data_q[WUT_BIT_EN_PENDING] == $past(en_pend_q)))
        else $error("Status frozen or pending bit disagrees with state.");

    // A clear written away from a slow edge must be captured in the requests on the next cycle.
    chk_clear_capture: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && addr == WUT_INT_CLEAR_ADDR && !slow_tick)
        |=> ((clr_q & $past(wr_data[WUT_NUM_SRC-1:0])) == $past(wr_data[WUT_NUM_SRC-1:0])))
        else $error("Clear request was not held.");

    chk_freeze_latch: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_en && addr == WUT_COUNT_LOW_ADDR && ctl_q[WUT_CTL_FREEZE])
        |=> (frozen_q && hold_q == $past(count[31:16])))
        else $error("High half not latched on low read.");

    chk_unfreeze_read: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_en && addr == WUT_COUNT_HIGH_ADDR && frozen_q)
        |=> (!frozen_q && rd_data_q[15:0] == $past(hold_q)))
        else $error("High read did not return and release the frozen value.");

endmodule : wut_irq_top

// [verification/tb_wakeup_timer_interrupts.sv]
// Self-checking testbench for the wake-up timer compare, status and interrupt block.
`timescale 1ns/1ps
module tb_wakeup_timer_interrupts
    import wut_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////////
    logic sys_clk = 1'b0; // Core clock, 25 MHz.
    logic rst = 1'b1; // Asynchronous reset, held at start.
    logic slow_tick = 1'b0; // Stand-in for one slow-domain edge.
    logic match_b = 1'b0; // Field B hit pulse.
    logic match_c = 1'b0; // Field C hit pulse.
    logic [31:0] addr = 32'h0; // Register address.
    logic [31:0] wr_data = 32'h0; // Register write data.
    logic wr_en = 1'b0; // Write strobe.
    logic rd_en = 1'b0; // Read strobe.
    logic [31:0] rd_data_q; // Registered read data.
    logic irq_q; // Level interrupt.
    int error_cnt = 0; // Mismatches seen.
    int checks_done = 0; // Comparisons made.

    // The clock toggles every half period of 20 ns.
    always #20 sys_clk = ~sys_clk;

    wut_irq_top i_wut_irq_top (
        .sys_clk(sys_clk), .rst(rst), .slow_tick(slow_tick), .match_b(match_b),
        .match_c(match_c), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data_q(rd_data_q), .irq_q(irq_q));

    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One-cycle write strobe; the slave never stalls, so no wait is needed.
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : reg_wr

    // Read data stands only in the cycle after the strobe, then must return to zero.
    task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data_q;
        @(posedge sys_clk);
        #1;
        chk(rd_data_q, 32'h0, "read data not dropped");
    endtask : reg_rd

    // Reads a register and compares it with the expected value.
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        reg_rd(a, v);
        chk(v, exp, what);
    endtask : rd_chk

    // One-cycle pulse on a chosen event input: 0 tick, 1 field B, 2 field C.
    task automatic pulse(input int which);
        @(posedge sys_clk);
        if (which == 0) slow_tick <= 1'b1;
        else if (which == 1) match_b <= 1'b1;
        else match_c <= 1'b1;
        @(posedge sys_clk);
        slow_tick <= 1'b0;
        match_b <= 1'b0;
        match_c <= 1'b0;
    endtask : pulse

    // Checks the interrupt after its two-cycle registered path has settled.
    task automatic irq_chk(input logic exp, input string what);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({31'h0, irq_q}, {31'h0, exp}, what);
    endtask : irq_chk

    // Polls the pending bit with slow edges until power-down would be safe.
    task automatic wait_pd_ok();
        logic [31:0] v;
        int n;
        n = 0;
        reg_rd(WUT_STATUS_ADDR, v);
        while (v[WUT_BIT_IRQ_PENDING] && n < 8) begin
            pulse(0);
            reg_rd(WUT_STATUS_ADDR, v);
            n++;
        end
        chk({31'h0, v[WUT_BIT_IRQ_PENDING]}, 32'h0, "pending bit never fell");
    endtask : wait_pd_ok

    ////////////////////////////////////////////////////////////////////////////////
    // Every register except the two count halves must come out of reset with its documented value.
    task automatic t_reset();
        rd_chk(WUT_FIELD_D_LOW_ADDR, 32'h0000_3fff, "field D low reset");
        rd_chk(WUT_FIELD_D_HIGH_ADDR, 32'h0, "field D high reset");
        rd_chk(WUT_FIELD_A_LOW_ADDR, 32'h0000_1900, "field A low reset");
        rd_chk(WUT_FIELD_A_HIGH_ADDR, 32'h0, "field A high reset");
        rd_chk(WUT_INT_ENABLE_ADDR, 32'h0, "enable reset");
        rd_chk(WUT_STATUS_ADDR, 32'h0, "status reset");
        rd_chk(WUT_INT_CLEAR_ADDR, 32'h0, "clear reset");
        rd_chk(WUT_CONTROL_ADDR, 32'h0000_0002, "control reset");
        chk({31'h0, irq_q}, 32'h0, "irq after reset");
    endtask : t_reset

    // Field halves are independent; reserved enable bits read zero; holes ignore writes.
    task automatic t_regs();
        reg_wr(WUT_FIELD_D_LOW_ADDR, 32'h0000_a5c3);
        reg_wr(WUT_FIELD_D_HIGH_ADDR, 32'h0000_5a3c);
        reg_wr(WUT_FIELD_A_LOW_ADDR, 32'h0000_c3a5);
        reg_wr(WUT_FIELD_A_HIGH_ADDR, 32'h0000_3c5a);
        rd_chk(WUT_FIELD_D_LOW_ADDR, 32'h0000_a5c3, "field D low");
        rd_chk(WUT_FIELD_D_HIGH_ADDR, 32'h0000_5a3c, "field D high");
        rd_chk(WUT_FIELD_A_LOW_ADDR, 32'h0000_c3a5, "field A low");
        rd_chk(WUT_FIELD_A_HIGH_ADDR, 32'h0000_3c5a, "field A high");
        reg_wr(WUT_INT_ENABLE_ADDR, 32'h0000_ffff);
        rd_chk(WUT_INT_ENABLE_ADDR, 32'h0000_001f, "enable width");
        reg_wr(WUT_INT_ENABLE_ADDR, 32'h0);
        reg_wr(WUT_STATUS_ADDR, 32'h0000_ffff);
        rd_chk(WUT_STATUS_ADDR, 32'h0, "status is read-only");
        reg_wr(32'h4000_2534, 32'h0000_ffff);
        rd_chk(32'h4000_2534, 32'h0, "unmapped read");
    endtask : t_regs

    // External hits set sticky flags; only enabled flags raise the interrupt.
    task automatic t_flags();
        pulse(2);
        rd_chk(WUT_STATUS_ADDR, 32'h0000_0044, "field C flag");
        irq_chk(1'b0, "masked flag raised irq");
        reg_wr(WUT_INT_ENABLE_ADDR, 32'h0000_0004);
        irq_chk(1'b1, "enabled flag no irq");
        pulse(1);
        rd_chk(WUT_STATUS_ADDR, 32'h0000_0046, "field B flag");
        reg_wr(WUT_INT_CLEAR_ADDR, 32'h0000_0004);
        rd_chk(WUT_INT_CLEAR_ADDR, 32'h0000_0004, "clear pending");
        rd_chk(WUT_STATUS_ADDR, 32'h0000_0046, "flag dropped before tick");
        pulse(0);
        rd_chk(WUT_INT_CLEAR_ADDR, 32'h0, "clear not self-cleared");
        rd_chk(WUT_STATUS_ADDR, 32'h0000_0042, "only C cleared");
        irq_chk(1'b0, "irq after clear");
        reg_wr(WUT_INT_CLEAR_ADDR, 32'h0000_0002);
        pulse(0);
        rd_chk(WUT_STATUS_ADDR, 32'h0, "pending bit after last clear");
        reg_wr(WUT_INT_ENABLE_ADDR, 32'h0);
    endtask : t_flags

    // Periodic count with A and D hits, enable sync and the frozen high half.
    task automatic t_count();
        logic [31:0] v;
        reg_wr(WUT_FIELD_A_LOW_ADDR, 32'h0000_0003);
        reg_wr(WUT_FIELD_A_HIGH_ADDR, 32'h0);
        reg_wr(WUT_FIELD_D_LOW_ADDR, 32'h0000_0006);
        reg_wr(WUT_FIELD_D_HIGH_ADDR, 32'h0);
        reg_wr(WUT_INT_ENABLE_ADDR, 32'h0000_0009);
        reg_wr(WUT_CONTROL_ADDR, 32'h0000_0005);
        rd_chk(WUT_STATUS_ADDR, 32'h0000_0100, "enable sync pending");
        pulse(0);
        rd_chk(WUT_STATUS_ADDR, 32'h0, "enable sync done");
        repeat (20) pulse(0);
        rd_chk(WUT_STATUS_ADDR, 32'h0000_0049, "A and D hit, no roll");
        irq_chk(1'b1, "irq on A or D");
        reg_rd(WUT_COUNT_LOW_ADDR, v);
        chk({31'h0, v > 32'h6}, 32'h0, "periodic count above D");
        rd_chk(WUT_STATUS_ADDR, 32'h0000_00c9, "high half frozen");
        rd_chk(WUT_COUNT_HIGH_ADDR, 32'h0, "frozen high half");
        rd_chk(WUT_STATUS_ADDR, 32'h0000_0049, "unfreeze on high read");
        reg_wr(WUT_CONTROL_ADDR, 32'h0000_0004);
        pulse(0);
        reg_wr(WUT_INT_CLEAR_ADDR, 32'h0000_0009);
        wait_pd_ok();
        rd_chk(WUT_STATUS_ADDR, 32'h0, "status after clear");
        irq_chk(1'b0, "irq after clear");
    endtask : t_count

    ////////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // Main sequence; reset is held for ten cycles before the first request.
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_flags();
        t_count();
        summarize();
    end

    // Watchdog: a hang counts as a mismatch and goes to the report.
    initial begin
        #(40 * 20000);
        error_cnt++;
        $display("[FAIL] %0t run did not finish", $time);
        summarize();
    end
endmodule : tb_wakeup_timer_interrupts
